// ==== logic/shi2c_pkg.sv ====
// Package for the sensor hub host I2C target port: constants and carrier types
package shi2c_pkg;

    // Address: six fixed upper bits, low bit from strap
    localparam logic [5:0] SHI2C_ADDR_HI       = 6'h25;
    // Cycle counts at 125 MHz
    localparam int         SHI2C_CLK_MHZ       = 125;
    // Strap settle time with pulldown enabled, in ns
    localparam int         SHI2C_STRAP_SET_NS  = 1000;
    localparam int         SHI2C_STRAP_CYC     =
        (SHI2C_STRAP_SET_NS * SHI2C_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SHI2C_STRAP_CYC_W   = 8'(SHI2C_STRAP_CYC);
    // Reset values and the acknowledge bit count
    localparam logic [7:0] SHI2C_RST_BYTE      = 8'h00;
    localparam logic [3:0] SHI2C_RST_CNT       = 4'h0;
    localparam logic [3:0] SHI2C_ACK_BIT       = 4'h8;
    // Protocol select code for I2C host mode
    localparam logic [1:0] SHI2C_PROTO_I2C     = 2'h0;

    // Clock source selection
    typedef enum logic [1:0] {
        SHI2C_SRC_CRYSTAL,
        SHI2C_SRC_EXTERNAL,
        SHI2C_SRC_INTERNAL
    } shi2c_src_t;

    // Strap sampling sequence
    typedef enum logic [2:0] {
        SHI2C_ST_SET_A,
        SHI2C_ST_SET_B,
        SHI2C_ST_DONE
    } shi2c_strap_st_t;

    // Bus sequence
    typedef enum logic [2:0] {
        SHI2C_BS_IDLE,
        SHI2C_BS_ADDR,
        SHI2C_BS_ACK,
        SHI2C_BS_WRITE,
        SHI2C_BS_READ,
        SHI2C_BS_RACK,
        SHI2C_BS_IGNORE
    } shi2c_bus_st_t;

    // Strap results carried together
    typedef struct packed {
        logic       done;
        logic       i2c;
        logic       addr_lsb;
        logic       loader;
        logic [1:0] proto;
        shi2c_src_t src;
    } shi2c_straps_t;

    // Whole module state
    typedef struct packed {
        shi2c_strap_st_t sst;
        logic [7:0]      scnt;
        logic            pd_a;
        logic            pd_b;
        shi2c_straps_t   cfg;
        shi2c_bus_st_t   bst;
        logic            scl_p;
        logic            sda_p;
        logic [3:0]      bit_cnt;
        logic [7:0]      shreg;
        logic            rd;
        logic            sda_oe_n;
        logic            scl_oe_n;
        logic [7:0]      rx_byte;
        logic            rx_vld;
        logic            rx_first;
        logic            tx_take;
        logic            busy;
        logic            attn_n;
    } shi2c_state_t;

endpackage : shi2c_pkg

// ==== logic/shi2c_target.sv ====
// Host I2C target port with reset-time strap sampling and host attention line
// Summary of operation
// - Answer address 100101 plus strapped low bit, 0x4A or 0x4B.
// - Address strap latched at reset; board holds it fixed.
// - Oversampled logic works at Standard and Fast mode rates.
// - Lines only pulled low; released for one.
// - Bus busy from start to stop; between, a new start is sought only in the ignore state.
// - Bytes are eight bits, MSB first; data changes while clock low.
// - Multi-byte words go least significant byte first.
// - Receiver pulls data low for the ninth clock pulse.
// - Target may stretch clock low until ready; controller waits.
// - First byte is address plus direction bit, zero means write.
// - On write, address and every data byte acknowledged until stop.
// - On read, target sends bytes; controller NAKs last then stops.
// - No repeated start; controller ends each transfer with stop.
// - Clock source from two straps: crystal, external or internal.
// - First clock strap pulldown on at start, off if read one.
// - For external or internal, sample second strap with pulldown, off if one.
// - Active-low host attention output.
// - Boot strap low at reset enters firmware-loader mode.
// - Protocol and boot straps latched at reset; 00 is I2C.
`timescale 1ns/1ns
`default_nettype none

module shi2c_target
    import shi2c_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_chip_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_addr_lsb_strap,
    input  wire logic       i_loader_strap_n,
    input  wire logic       i_proto_sel_hi,
    input  wire logic       i_proto_sel_lo_wake,
    input  wire logic       i_clk_src_strap_a,
    input  wire logic       i_clk_src_strap_b,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_ready,
    input  wire logic       i_attn_req,
    output logic            o_scl_oe_n,
    output logic            o_sda_oe_n,
    output logic            o_clk_src_a_pd,
    output logic            o_clk_src_b_pd,
    output logic [1:0]      o_clk_src,
    output logic            o_loader_mode,
    output logic            o_i2c_selected,
    output logic            o_straps_done,
    output logic [7:0]      o_rx_byte,
    output logic            o_rx_valid,
    output logic            o_rx_first,
    output logic            o_tx_take,
    output logic            o_busy,
    output logic            o_host_attention_n
);

    shi2c_state_t q;
    shi2c_state_t d;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_seen;
    logic         stop_seen;

    // Settle window over for the strap now being sampled
    function automatic logic settle_done(input logic [7:0] cnt);
        return cnt == SHI2C_STRAP_CYC_W;
    endfunction : settle_done

    // Edge and condition detection on the sampled lines
    // Previous samples reset high, the idle level, so release gives no false edge
    assign scl_rise   = i_scl & ~q.scl_p;
    assign scl_fall   = ~i_scl & q.scl_p;
    assign start_seen = i_scl & q.scl_p & q.sda_p & ~i_sda;
    assign stop_seen  = i_scl & q.scl_p & ~q.sda_p & i_sda;

    // Next state for straps and bus
    always_comb
    begin
        d          = q;
        d.scl_p    = i_scl;
        d.sda_p    = i_sda;
        d.rx_vld   = 1'b0;
        d.tx_take  = 1'b0;
        d.attn_n   = ~i_attn_req;
        // Strap sequence: let pulldowns settle before each sample
        case (q.sst)
            SHI2C_ST_SET_A:
            begin
                d.scnt = q.scnt + 8'h01;
                if (settle_done(q.scnt))
                begin
                    d.scnt         = SHI2C_RST_BYTE;
                    d.cfg.addr_lsb = i_addr_lsb_strap;
                    d.cfg.loader   = ~i_loader_strap_n;
                    d.cfg.proto    = {i_proto_sel_hi, i_proto_sel_lo_wake};
                    if (i_clk_src_strap_a)
                    begin
                        d.pd_a = 1'b0;
                        d.pd_b = 1'b1;
                        d.sst  = SHI2C_ST_SET_B;
                    end
                    else
                    begin
                        d.cfg.src  = SHI2C_SRC_CRYSTAL;
                        d.cfg.done = 1'b1;
                        d.sst      = SHI2C_ST_DONE;
                    end
                end
            end
            SHI2C_ST_SET_B:
            begin
                d.scnt = q.scnt + 8'h01;
                if (settle_done(q.scnt))
                begin
                    // Open strap b reads its pulldown low, so open means internal
                    d.cfg.src  = i_clk_src_strap_b ? SHI2C_SRC_EXTERNAL
                                                   : SHI2C_SRC_INTERNAL;
                    d.pd_b     = ~i_clk_src_strap_b;
                    d.cfg.done = 1'b1;
                    d.sst      = SHI2C_ST_DONE;
                end
            end
            default:
            begin
                d.sst = SHI2C_ST_DONE;
            end
        endcase
        // Registered so the select output comes straight from a flop
        d.cfg.i2c = d.cfg.done && (d.cfg.proto == SHI2C_PROTO_I2C);

        // Bus engine runs only once straps are known and I2C is chosen
        // Limitation: a host talking before the straps settle goes unseen
        if (!q.cfg.done || q.cfg.proto != SHI2C_PROTO_I2C)
        begin
            d.bst      = SHI2C_BS_IDLE;
            d.sda_oe_n = 1'b1;
            d.scl_oe_n = 1'b1;
            d.busy     = 1'b0;
        end
        else if (stop_seen)
        begin
            // A stop ends any state, but not a stretch: the held clock stays low, so no stop is seen until ready
            d.bst      = SHI2C_BS_IDLE;
            d.sda_oe_n = 1'b1;
            d.scl_oe_n = 1'b1;
            d.busy     = 1'b0;
        end
        else if (start_seen && (q.bst == SHI2C_BS_IDLE || q.bst == SHI2C_BS_IGNORE))
        begin
            // Mid-transfer starts are honoured only from the ignore state; otherwise no repeated start
            d.bst      = SHI2C_BS_ADDR;
            d.busy     = 1'b1;
            d.bit_cnt  = SHI2C_RST_CNT;
            d.rx_first = 1'b1;
            d.sda_oe_n = 1'b1;
        end
        else
        begin
            case (q.bst)
                SHI2C_BS_ADDR, SHI2C_BS_WRITE:
                begin
                    if (scl_rise)
                    begin
                        d.shreg   = {q.shreg[6:0], i_sda};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                    if (scl_fall && q.bit_cnt == SHI2C_ACK_BIT)
                    begin
                        d.bit_cnt = SHI2C_RST_CNT;
                        if (q.bst == SHI2C_BS_ADDR)
                        begin
                            // direction bit sits in the low position
                            if (q.shreg[7:1] == {SHI2C_ADDR_HI, q.cfg.addr_lsb})
                            begin
                                d.rd       = q.shreg[0];
                                d.sda_oe_n = 1'b0;
                                d.bst      = SHI2C_BS_ACK;
                            end
                            else
                            begin
                                // No ack: the controller sees a NAK and must stop
                                d.bst = SHI2C_BS_IGNORE;
                            end
                        end
                        else
                        begin
                            d.rx_byte  = q.shreg;
                            d.rx_vld   = 1'b1;
                            d.rx_first = 1'b0;
                            d.sda_oe_n = 1'b0;
                            d.bst      = SHI2C_BS_ACK;
                        end
                    end
                end
                SHI2C_BS_ACK:
                begin
                    // Ninth pulse over, or still stretching after it
                    if (scl_fall || !q.scl_oe_n)
                    begin
                        if (q.rd && !i_tx_ready)
                        begin
                            // Stretch only after the ack pulse, so the ack is seen
                            d.sda_oe_n = 1'b1;
                            d.scl_oe_n = 1'b0;
                        end
                        else if (q.rd)
                        begin
                            // Clock stays as it is; data leads any release
                            d.shreg    = {i_tx_byte[6:0], 1'b0};
                            d.sda_oe_n = i_tx_byte[7];
                            d.tx_take  = 1'b1;
                            d.bit_cnt  = 4'h1;
                            d.bst      = SHI2C_BS_READ;
                        end
                        else
                        begin
                            d.sda_oe_n = 1'b1;
                            d.bst      = SHI2C_BS_WRITE;
                        end
                    end
                end
                SHI2C_BS_READ:
                begin
                    // Clock let go one cycle after the first bit is set up
                    d.scl_oe_n = 1'b1;
                    if (scl_fall)
                    begin
                        if (q.bit_cnt == SHI2C_ACK_BIT)
                        begin
                            d.sda_oe_n = 1'b1;
                            d.bst      = SHI2C_BS_RACK;
                        end
                        else
                        begin
                            d.sda_oe_n = q.shreg[7];
                            d.shreg    = {q.shreg[6:0], 1'b0};
                            d.bit_cnt  = q.bit_cnt + 4'h1;
                        end
                    end
                end
                SHI2C_BS_RACK:
                begin
                    // Controller NAK ends sending; wait for the stop
                    if (scl_rise)
                    begin
                        d.bst = i_sda ? SHI2C_BS_IGNORE : SHI2C_BS_ACK;
                    end
                end
                default:
                begin
                    d.sda_oe_n = 1'b1;
                    d.scl_oe_n = 1'b1;
                end
            endcase
        end
    end

    // State register, synchronous active-low reset
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_chip_reset_n)
        begin
            q          <= '0;
            q.sst      <= SHI2C_ST_SET_A;
            q.scnt     <= SHI2C_RST_BYTE;
            q.pd_a     <= 1'b1;
            q.pd_b     <= 1'b0;
            q.bst      <= SHI2C_BS_IDLE;
            q.scl_p    <= 1'b1;
            q.sda_p    <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.scl_oe_n <= 1'b1;
            q.attn_n   <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign o_scl_oe_n         = q.scl_oe_n;
    assign o_sda_oe_n         = q.sda_oe_n;
    assign o_clk_src_a_pd     = q.pd_a;
    assign o_clk_src_b_pd     = q.pd_b;
    assign o_clk_src          = q.cfg.src;
    assign o_loader_mode      = q.cfg.loader;
    assign o_i2c_selected     = q.cfg.i2c;
    assign o_straps_done      = q.cfg.done;
    assign o_rx_byte          = q.rx_byte;
    assign o_rx_valid         = q.rx_vld;
    assign o_rx_first         = q.rx_first;
    assign o_tx_take          = q.tx_take;
    assign o_busy             = q.busy;
    assign o_host_attention_n = q.attn_n;

endmodule : shi2c_target

`default_nettype wire

// ==== test/shi2c_host_model.sv ====
// Behavioural I2C controller standing in for the host microcontroller
`timescale 1ns/1ns
`default_nettype none
module shi2c_host_model
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [9:0] i_quarter,
    output var  logic       o_scl_oe_n,
    output var  logic       o_sda_oe_n,
    output var  logic       o_hang
);
    // Both lines released from time zero
    initial
    begin
        o_scl_oe_n = 1'h1;
        o_sda_oe_n = 1'h1;
        o_hang     = 1'h0;
    end
    // Quarter bit periods; the rate is set by the bench
    task automatic wq(input int n);
        repeat (n * int'(i_quarter)) @(posedge i_sys_clk);
    endtask : wq
    // Lines are only pulled low or released to the pull-up
    task automatic start_c();
        o_sda_oe_n <= 1'h0;
        wq(1);
        o_scl_oe_n <= 1'h0;
        wq(1);
    endtask : start_c
    // Every transfer ends here; never a repeated start
    task automatic stop_c();
        o_sda_oe_n <= 1'h0;
        wq(1);
        o_scl_oe_n <= 1'h1;
        wq(1);
        o_sda_oe_n <= 1'h1;
        wq(2);
    endtask : stop_c
    // One clock pulse; data set while low, stretching waited out with a bound
    task automatic bit_c(input logic b, output logic r);
        int k;
        o_sda_oe_n <= b;
        wq(1);
        o_scl_oe_n <= 1'h1;
        @(posedge i_sys_clk);
        for (k = 0; k < 20000 && i_scl !== 1'h1; k++) @(posedge i_sys_clk);
        if (k == 20000) o_hang <= 1'h1;
        wq(1);
        r = i_sda;
        wq(1);
        o_scl_oe_n <= 1'h0;
        wq(1);
    endtask : bit_c
    // Byte MSB first, then the acknowledge pulse
    task automatic byte_c(input logic [7:0] tx, input logic a_in,
                          output logic [7:0] rx, output logic a_out);
        for (int i = 7; i >= 0; i--) bit_c(tx[i], rx[i]);
        bit_c(a_in, a_out);
    endtask : byte_c
endmodule : shi2c_host_model
`default_nettype wire

// ==== test/shi2c_target_asserts.sv ====
// Assertion checker for the host I2C target port, bound to its pins
`timescale 1ns/1ns
`default_nettype none
module shi2c_target_asserts
    import shi2c_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_chip_reset_n,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       i_addr_lsb_strap,
    input wire logic       i_loader_strap_n,
    input wire logic       i_proto_sel_hi,
    input wire logic       i_proto_sel_lo_wake,
    input wire logic       i_clk_src_strap_a,
    input wire logic       i_clk_src_strap_b,
    input wire logic       i_tx_ready,
    input wire logic       i_attn_req,
    input wire logic [7:0] i_tx_byte,
    input wire logic [7:0] o_rx_byte,
    input wire logic [1:0] o_clk_src,
    input wire logic       o_scl_oe_n,
    input wire logic       o_sda_oe_n,
    input wire logic       o_clk_src_a_pd,
    input wire logic       o_clk_src_b_pd,
    input wire logic       o_loader_mode,
    input wire logic       o_i2c_selected,
    input wire logic       o_straps_done,
    input wire logic       o_rx_valid,
    input wire logic       o_rx_first,
    input wire logic       o_tx_take,
    input wire logic       o_busy,
    input wire logic       o_host_attention_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_chip_reset_n);
    // Bus conditions on the resolved lines; start counts only for an idle target
    sequence start_s;
        i_scl && $past(i_scl) && $fell(i_sda) && o_straps_done && o_i2c_selected && !o_busy;
    endsequence
    sequence stop_s;
        i_scl && $past(i_scl) && $rose(i_sda);
    endsequence
    start_busy_a: assert property (start_s |-> ##[1:4] o_busy)
        else $error("busy not raised after start");
    stop_idle_a: assert property (stop_s |-> ##[1:4] !o_busy)
        else $error("busy not cleared after stop");
    idle_release_a: assert property (!o_busy [*2] |-> o_sda_oe_n && o_scl_oe_n)
        else $error("line pulled while bus idle");
    ack_with_byte_a: assert property (o_rx_valid |-> !o_sda_oe_n && o_busy)
        else $error("received byte not acknowledged");
    take_pulse_a: assert property (o_tx_take |=> !o_tx_take)
        else $error("take held longer than one cycle");
    stretch_end_a: assert property ($rose(i_tx_ready) && !o_scl_oe_n |-> ##[1:4] o_scl_oe_n)
        else $error("clock still held after ready");
    attn_follow_a: assert property ($past(i_chip_reset_n) |->
        o_host_attention_n == !$past(i_attn_req))
        else $error("attention line does not follow request");
    src_decode_a: assert property (o_straps_done |->
        o_clk_src == (i_clk_src_strap_a ? (i_clk_src_strap_b ? 2'h1 : 2'h2) : 2'h0))
        else $error("clock source decode wrong");
    pd_a_power_a: assert property (o_straps_done |-> o_clk_src_a_pd == !i_clk_src_strap_a)
        else $error("first strap pulldown wrong");
    pd_b_power_a: assert property (o_straps_done |->
        o_clk_src_b_pd == (i_clk_src_strap_a && !i_clk_src_strap_b))
        else $error("second strap pulldown wrong");
    mode_latch_a: assert property (o_straps_done |-> o_loader_mode == !i_loader_strap_n &&
        o_i2c_selected == !(i_proto_sel_hi || i_proto_sel_lo_wake))
        else $error("mode straps latched wrong");
endmodule : shi2c_target_asserts
bind shi2c_target shi2c_target_asserts u_asserts (.*);
`default_nettype wire

// ==== test/shi2c_target_tb_top.sv ====
// Self-checking bench for the host I2C target port
`timescale 1ns/1ns
`default_nettype none
module shi2c_target_tb_top
    import shi2c_pkg::*;
();
    logic       i_sys_clk, i_chip_reset_n, i_addr_lsb_strap, i_loader_strap_n, i_proto_sel_hi;
    logic       i_proto_sel_lo_wake, i_clk_src_strap_a, i_clk_src_strap_b, i_tx_ready;
    logic       i_attn_req, o_scl_oe_n, o_sda_oe_n, o_clk_src_a_pd, o_clk_src_b_pd;
    logic       o_loader_mode, o_i2c_selected, o_straps_done, o_rx_valid, o_rx_first;
    logic       o_tx_take, o_busy, o_host_attention_n, h_scl_n, h_sda_n, h_hang;
    logic [7:0] i_tx_byte, o_rx_byte, rx_q[$], tx_q[$];
    logic [1:0] o_clk_src;
    logic [9:0] quarter;
    int         mismatches, num_checks;
    // Pull-ups: a line is low when any party pulls it
    wire        i_scl = h_scl_n & o_scl_oe_n;
    wire        i_sda = h_sda_n & o_sda_oe_n;
    shi2c_target DUT (.*);
    shi2c_host_model u_host (.i_sys_clk, .i_scl, .i_sda, .i_quarter(quarter),
                             .o_scl_oe_n(h_scl_n), .o_sda_oe_n(h_sda_n), .o_hang(h_hang));
    initial
    begin
        i_sys_clk = 1'h0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // Collect received bytes; present the next read byte; a host hang ends the run
    always @(posedge i_sys_clk)
    begin
        if (h_hang === 1'h1) finish_test();
        if (o_rx_valid === 1'h1) rx_q.push_back(o_rx_byte);
        if (o_tx_take === 1'h1) i_tx_byte <= (tx_q.size() > 0) ? tx_q.pop_front() : 8'h00;
    end
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        if (h_hang !== 1'h0) mismatches++;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // Straps change only while reset is held; bounded wait for sampling
    task automatic reset_dut(input logic [4:0] s);
        int k;
        {i_clk_src_strap_a, i_clk_src_strap_b, i_loader_strap_n, i_proto_sel_hi,
         i_proto_sel_lo_wake} <= s;
        i_chip_reset_n <= 1'h0;
        repeat (2) @(posedge i_sys_clk);
        i_chip_reset_n <= 1'h1;
        for (k = 0; k < 1000 && o_straps_done !== 1'h1; k++) @(posedge i_sys_clk);
        if (k == 1000)
        begin
            mismatches++;
            finish_test();
        end
    endtask : reset_dut
    function automatic logic [1:0] exp_src(input logic a, input logic b);
        return !a ? 2'h0 : (b ? 2'h1 : 2'h2);
    endfunction : exp_src
    initial
    begin
        logic [7:0] r;
        logic [7:0] d[3];
        logic       a;
        {i_chip_reset_n, i_addr_lsb_strap, i_proto_sel_hi, i_proto_sel_lo_wake, i_attn_req} = '0;
        {i_clk_src_strap_a, i_clk_src_strap_b, i_tx_byte} = '0;
        {i_loader_strap_n, i_tx_ready} = 2'h3;
        quarter = 10'h04E;
        void'($urandom(96482));
        @(posedge i_sys_clk);
        // Every combination of clock, boot and protocol straps, address strap held low, except internal clock with protocol code 01 or 10
        for (int i = 0; i < 32; i++)
        begin
            // Internal clock never paired with a UART protocol code
            if (i[4] && !i[3] && (i[1] ^ i[0])) continue;
            // External picks stand for a board feeding the crystal input
            reset_dut(5'(i));
            chk(8'(o_clk_src), 8'(exp_src(i[4], i[3])));
            chk(8'(o_clk_src_a_pd), 8'(!i[4]));
            chk(8'(o_clk_src_b_pd), 8'(i[4] && !i[3]));
            chk(8'(o_loader_mode), 8'(!i[2]));
            chk(8'(o_i2c_selected), 8'(i[1:0] == 2'h0));
        end
        // Last code selects another protocol: the port must stay deaf
        u_host.start_c();
        u_host.byte_c({SHI2C_ADDR_HI, 1'h0, 1'h0}, 1'h1, r, a);
        chk(8'(a), 8'h01);
        chk(8'(o_busy), 8'h00);
        u_host.stop_c();
        $display("strap test done");
        // Writes at Standard then Fast rate, address strap both ways
        for (int m = 0; m < 2; m++)
        begin
            i_addr_lsb_strap <= m[0];
            quarter <= m[0] ? 10'h04E : 10'h138;
            reset_dut(5'h04 | (5'($urandom) & 5'h18));
            rx_q.delete();
            u_host.start_c();
            chk(8'(o_busy), 8'h01);
            u_host.byte_c({SHI2C_ADDR_HI, m[0], 1'h0}, 1'h1, r, a);
            chk(8'(a), 8'h00);
            chk(8'(o_rx_first), 8'h01);
            d[0] = m[0] ? 8'h00 : 8'hFF;
            d[1] = 8'($urandom);
            for (int j = 0; j < 2; j++)
            begin
                u_host.byte_c(d[j], 1'h1, r, a);
                chk(8'(a), 8'h00);
            end
            chk(8'(o_rx_first), 8'h00);
            u_host.stop_c();
            chk(8'(o_busy), 8'h00);
            chk(8'(rx_q.size()), 8'h02);
            for (int j = 0; j < 2; j++) chk(rx_q[j], d[j]);
        end
        $display("write test done");
        // Other addresses: unacknowledged, nothing received
        rx_q.delete();
        for (int j = 0; j < 2; j++)
        begin
            u_host.start_c();
            u_host.byte_c({j[0] ? ~SHI2C_ADDR_HI : SHI2C_ADDR_HI, 1'h0, 1'h0}, 1'h1, r, a);
            chk(8'(a), 8'h01);
            u_host.byte_c(8'($urandom), 1'h1, r, a);
            chk(8'(a), 8'h01);
            u_host.stop_c();
        end
        chk(8'(rx_q.size()), 8'h00);
        $display("address test done");
        // Read with the target stretching before the first byte
        for (int j = 0; j < 3; j++) d[j] = 8'($urandom);
        i_tx_byte <= d[0];
        tx_q = '{d[1], d[2]};
        i_tx_ready <= 1'h0;
        u_host.start_c();
        u_host.byte_c({SHI2C_ADDR_HI, 1'h1, 1'h1}, 1'h1, r, a);
        chk(8'(a), 8'h00);
        fork
            begin
                repeat (200) @(posedge i_sys_clk);
                chk(8'(i_scl), 8'h00);
                i_tx_ready <= 1'h1;
            end
            u_host.byte_c(8'hFF, 1'h0, r, a);
        join
        chk(r, d[0]);
        for (int j = 1; j < 3; j++)
        begin
            u_host.byte_c(8'hFF, j == 2, r, a);
            chk(r, d[j]);
        end
        u_host.stop_c();
        $display("read test done");
        // Attention line follows the request, inverted
        for (int j = 0; j < 8; j++)
        begin
            a = 1'($urandom);
            i_attn_req <= a;
            repeat (2) @(posedge i_sys_clk);
            #1 chk(8'(o_host_attention_n), 8'(!a));
            @(posedge i_sys_clk);
        end
        $display("attention test done");
        finish_test();
    end
endmodule : shi2c_target_tb_top
`default_nettype wire
